// ### rtl/dac_clk_map.svh
// offsets, field positions, reset values and counts of the clock-mode block
`ifndef DAC_CLK_MAP_SVH
`define DAC_CLK_MAP_SVH
`define IDX_CTRL0 4'h0
`define IDX_FUNC 4'h1
`define IDX_LOOP 4'h2
`define IDX_CLKSEL 4'h3
`define IDX_LOOP_ALT 4'h4
`define IDX_CFG 4'h5
`define IDX_STAT 4'h6
`define IDX_MULT 4'h7
`define ADDR_HI_ZERO 2'b00
`define BIT_LOCK 1
`define BIT_PD 3
`define BIT_SLEEP 4
`define BIT_FSEL 0
`define BIT_LOOP 7
`define BIT_CKSEL 7
`define BIT_OVF 0
`define CFG_INTERP_LSB 0
`define CFG_PRESC_LSB 2
`define CFG_ZS 4
`define CFG_ONEPORT 5
`define RST_REG 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define P2_SEL_BIT 14
`define PER_MAX 10'h3ff
`define LOCK_TOL 10'h001
`define RATE_FOR_ILV 2
`endif

// ### rtl/dac_clk_pkg.sv
// types shared by the clock-mode block
package dac_clk_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0] reg_t;
  typedef enum logic [2:0]
  {
    LK_IDLE = 3'b001,
    LK_ACQ = 3'b010,
    LK_LOCKED = 3'b100
  } lock_state_e;
endpackage

// ### rtl/pair_buffer.sv
// small shift-register buffer with valid and ready on both sides
`timescale 1ns/100ps
module pair_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_q[0];

  always_comb
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = CW'(cnt_q + 1'b1);
    else if (pop && !push)
      cnt_d = CW'(cnt_q - 1'b1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_valid <= (cnt_d != '0);
      in_ready <= (cnt_d != CW'(DEPTH));
    end
  end

  // entries shift toward slot zero on a pop
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_slot
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        mem_q[i] <= '0;
      else if (pop)
      begin
        if (push && (CW'(i) == CW'(cnt_q - 1'b1)))
          mem_q[i] <= in_data;
        else if (i < DEPTH - 1)
          mem_q[i] <= mem_q[(i < DEPTH - 1) ? i + 1 : i];
      end
      else if (push && (CW'(i) == cnt_q))
        mem_q[i] <= in_data;
    end
  end
endmodule

// ### rtl/dac_clock_mode_and_port_select.sv
// clock mode, pin steering and input port capture with an AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "dac_clk_map.svh"
module dac_clock_mode_and_port_select #(
  parameter int LOCK_PERIODS = 16,
  parameter int BUF_DEPTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic main_clock_in,
  input wire dac_clk_pkg::word_t port1_in,
  input wire dac_clk_pkg::word_t port2_in,
  output logic shared_clkout_lock_pin,
  output logic serial_data_out_pin,
  output logic second_port_bit_fifteen_out,
  output logic second_port_bit_fifteen_oe,
  output dac_clk_pkg::word_t i_data,
  output dac_clk_pkg::word_t q_data,
  output logic pair_valid,
  input wire logic pair_ready,
  output logic dac_output_enable,
  output wire logic [3:0] rate_enable,
  output logic [7:0] vco_multiple,
  output logic [4:0] dac_rate_multiple
);
  import dac_clk_pkg::*;

  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_map;
  logic wr_en;
  logic [3:0] wr_idx;
  logic rd_map;
  logic [31:0] rd_word;
  reg_t ctrl0_rd;
  logic pd_q;
  logic sleep_q;
  logic fsel_q;
  logic loop_en_q;
  logic cksel_q;
  reg_t cfg_q;
  logic ovf_q;
  logic ovf_set;
  logic ovf_clr;
  logic main_s1;
  logic main_s2;
  logic main_s3;
  word_t p1_s1;
  word_t p1_s2;
  word_t p2_s1;
  word_t p2_s2;
  logic main_rise;
  logic main_edge;
  logic [9:0] per_cnt_q;
  logic [9:0] per_q;
  logic [9:0] meas;
  logic close;
  lock_state_e lk_q;
  logic [7:0] stab_q;
  logic locked;
  logic oneport;
  logic [4:0] interp_n;
  logic [4:0] div_n;
  logic [15:0] data_per;
  logic run;
  logic [4:0] hcnt_q;
  logic dclk_div_q;
  logic int_dclk_q;
  logic dclk_prev_q;
  logic dclk_rise;
  logic sel_sig;
  logic ilv_q;
  logic ilv_rise_q;
  word_t hold_i_q;
  logic got_i_q;
  word_t pend_i_q;
  word_t pend_q_q;
  logic pend_v_q;
  logic buf_ready;
  logic new_pair;
  logic [31:0] buf_out;

  assign wr_idx = awaddr_q[5:2];
  assign wr_map = (awaddr_q[7:6] == `ADDR_HI_ZERO) && (wr_idx <= `IDX_MULT);
  assign wr_en = aw_got_q & w_got_q & ~bvalid & wr_map & wstrb_q[0];
  assign rd_map = (araddr[7:6] == `ADDR_HI_ZERO) && (araddr[5:2] <= `IDX_MULT);
  assign locked = (lk_q == LK_LOCKED);
  assign oneport = cfg_q[`CFG_ONEPORT];

  // write address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      aw_got_q <= 1'b1;
      awaddr_q <= awaddr;
    end
    else if (bvalid && bready)
      aw_got_q <= 1'b0;
    else if (!aw_got_q)
      awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready <= 1'b0;
      w_got_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      w_got_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
    else if (bvalid && bready)
      w_got_q <= 1'b0;
    else if (!w_got_q)
      wready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else if (aw_got_q && w_got_q && !bvalid)
    begin
      bvalid <= 1'b1;
      bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // control registers stay writable during power-down
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pd_q <= 1'b0;
      sleep_q <= 1'b0;
      fsel_q <= 1'b0;
      loop_en_q <= 1'b0;
      cksel_q <= 1'b0;
      cfg_q <= `RST_REG;
    end
    else if (wr_en)
    begin
      case (wr_idx)
        `IDX_CTRL0:
        begin
          pd_q <= wdata_q[`BIT_PD];
          sleep_q <= wdata_q[`BIT_SLEEP];
        end
        `IDX_FUNC: fsel_q <= wdata_q[`BIT_FSEL];
        `IDX_LOOP: loop_en_q <= wdata_q[`BIT_LOOP];
        `IDX_LOOP_ALT: loop_en_q <= wdata_q[`BIT_LOOP];
        `IDX_CLKSEL: cksel_q <= wdata_q[`BIT_CKSEL];
        `IDX_CFG: cfg_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // overflow flag, write one to clear, a new event wins
  assign ovf_clr = wr_en && (wr_idx == `IDX_STAT) && wdata_q[`BIT_OVF];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ovf_q <= 1'b0;
    else
      ovf_q <= ovf_set | (ovf_q & ~ovf_clr);
  end

  always_comb
  begin
    ctrl0_rd = `RST_REG;
    ctrl0_rd[`BIT_LOCK] = locked;
    ctrl0_rd[`BIT_PD] = pd_q;
    ctrl0_rd[`BIT_SLEEP] = sleep_q;
    rd_word = 32'h0000_0000;
    case (araddr[5:2])
      `IDX_CTRL0: rd_word[7:0] = ctrl0_rd;
      `IDX_FUNC: rd_word[`BIT_FSEL] = fsel_q;
      `IDX_LOOP: rd_word[`BIT_LOOP] = loop_en_q;
      `IDX_LOOP_ALT: rd_word[`BIT_LOOP] = loop_en_q;
      `IDX_CLKSEL: rd_word[`BIT_CKSEL] = cksel_q;
      `IDX_CFG: rd_word[7:0] = cfg_q;
      `IDX_STAT: rd_word[`BIT_OVF] = ovf_q;
      `IDX_MULT: rd_word[7:0] = vco_multiple;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_map ? rd_word : 32'h0000_0000;
      rresp <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
    else if (!rvalid)
      arready <= 1'b1;
  end

  // pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_s1 <= 1'b0;
      main_s2 <= 1'b0;
      main_s3 <= 1'b0;
      p1_s1 <= '0;
      p1_s2 <= '0;
      p2_s1 <= '0;
      p2_s2 <= '0;
    end
    else
    begin
      main_s1 <= main_clock_in;
      main_s2 <= main_s1;
      main_s3 <= main_s2;
      p1_s1 <= port1_in;
      p1_s2 <= p1_s1;
      p2_s1 <= port2_in;
      p2_s2 <= p2_s1;
    end
  end

  assign main_rise = main_s2 & ~main_s3;
  assign main_edge = main_s2 ^ main_s3;

  // input clock period in aclk cycles
  assign meas = 10'(per_cnt_q + 10'h001);
  assign close = ((meas > per_q) ? 10'(meas - per_q) : 10'(per_q - meas))
    <= `LOCK_TOL;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || pd_q)
    begin
      per_cnt_q <= '0;
      per_q <= '0;
    end
    else if (main_rise)
    begin
      per_cnt_q <= '0;
      per_q <= meas;
    end
    else if (per_cnt_q != `PER_MAX)
      per_cnt_q <= 10'(per_cnt_q + 10'h001);
  end

  // loop lock: stable input period over several edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lk_q <= LK_IDLE;
      stab_q <= '0;
    end
    else if (!loop_en_q || pd_q || per_cnt_q == `PER_MAX)
    begin
      lk_q <= LK_IDLE;
      stab_q <= '0;
    end
    else if (main_rise)
    begin
      case (lk_q)
        LK_IDLE:
        begin
          lk_q <= LK_ACQ;
          stab_q <= '0;
        end
        LK_ACQ:
          if (!close)
            stab_q <= '0;
          else if (stab_q == 8'(LOCK_PERIODS - 1))
            lk_q <= LK_LOCKED;
          else
            stab_q <= 8'(stab_q + 8'h01);
        LK_LOCKED:
          if (!close)
          begin
            lk_q <= LK_ACQ;
            stab_q <= '0;
          end
        default: lk_q <= LK_IDLE;
      endcase
    end
  end

  // rate ratios from the configuration
  assign interp_n = 5'h01 << cfg_q[`CFG_INTERP_LSB +: 2];
  assign div_n = interp_n << cfg_q[`CFG_ZS];
  // loop on, input is the data rate; off, it is the sample rate
  assign data_per = loop_en_q ? {6'h00, per_q} : 16'(per_q * div_n);
  assign run = loop_en_q ? locked : (per_q != '0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vco_multiple <= '0;
      dac_rate_multiple <= 5'h01;
    end
    else
    begin
      vco_multiple <= loop_en_q ?
        8'({3'h0, div_n} << cfg_q[`CFG_PRESC_LSB +: 2]) : 8'h00;
      dac_rate_multiple <= loop_en_q ? div_n : 5'h01;
    end
  end

  // aligned enables at 1x, 2x, 4x, 8x the data rate
  for (genvar k = 0; k < 4; k++)
  begin : g_rate
    logic [15:0] acc_q;
    logic [15:0] nxt;
    logic [3:0] sub_q;
    logic en_q;
    assign nxt = 16'(acc_q + (16'h0001 << k));
    assign rate_enable[k] = en_q;
    // a data clock rise restarts every rate, so no tick is lost or doubled
    always_ff @(posedge aclk)
    begin
      if (!aresetn || pd_q || !run)
      begin
        acc_q <= '0;
        sub_q <= '0;
        en_q <= 1'b0;
      end
      else if (dclk_rise)
      begin
        acc_q <= '0;
        sub_q <= '0;
        en_q <= 1'b1;
      end
      else if (nxt >= data_per && sub_q != 4'((1 << k) - 1))
      begin
        acc_q <= 16'(nxt - data_per);
        sub_q <= 4'(sub_q + 4'h1);
        en_q <= 1'b1;
      end
      else
      begin
        acc_q <= nxt;
        en_q <= 1'b0;
      end
    end
  end

  // divided data clock when the loop is off
  always_ff @(posedge aclk)
  begin
    if (!aresetn || pd_q || loop_en_q)
    begin
      hcnt_q <= '0;
      dclk_div_q <= 1'b0;
    end
    else if (main_edge)
    begin
      if (hcnt_q == 5'(div_n - 5'h01))
      begin
        hcnt_q <= '0;
        dclk_div_q <= ~dclk_div_q;
      end
      else
        hcnt_q <= 5'(hcnt_q + 5'h01);
    end
  end

  assign dclk_rise = int_dclk_q & ~dclk_prev_q;
  assign sel_sig = loop_en_q ? (fsel_q ? int_dclk_q : locked)
    : int_dclk_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_dclk_q <= 1'b0;
      dclk_prev_q <= 1'b0;
      shared_clkout_lock_pin <= 1'b0;
      serial_data_out_pin <= 1'b0;
      dac_output_enable <= 1'b0;
    end
    else
    begin
      int_dclk_q <= ~pd_q & (loop_en_q ? main_s2 : dclk_div_q);
      dclk_prev_q <= int_dclk_q;
      shared_clkout_lock_pin <= ~pd_q & ~cksel_q & sel_sig;
      serial_data_out_pin <= ~pd_q & cksel_q & sel_sig;
      dac_output_enable <= ~sleep_q & ~pd_q;
    end
  end

  // interleave clock toggles on every 4x enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn || pd_q || !oneport)
    begin
      ilv_q <= 1'b0;
      ilv_rise_q <= 1'b0;
    end
    else
    begin
      ilv_q <= ilv_q ^ rate_enable[`RATE_FOR_ILV];
      ilv_rise_q <= rate_enable[`RATE_FOR_ILV] & ~ilv_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      second_port_bit_fifteen_out <= 1'b0;
      second_port_bit_fifteen_oe <= 1'b0;
    end
    else
    begin
      second_port_bit_fifteen_out <= ilv_q;
      second_port_bit_fifteen_oe <= oneport & ~pd_q;
    end
  end

  assign new_pair = oneport ? (ilv_rise_q & p2_s2[`P2_SEL_BIT] & got_i_q)
    : dclk_rise;
  assign ovf_set = new_pair & pend_v_q & ~buf_ready & ~pd_q;

  // input capture, pair held until the buffer takes it or a new pair overwrites it
  always_ff @(posedge aclk)
  begin
    if (!aresetn || pd_q)
    begin
      hold_i_q <= '0;
      got_i_q <= 1'b0;
      pend_i_q <= '0;
      pend_q_q <= '0;
      pend_v_q <= 1'b0;
    end
    else
    begin
      if (pend_v_q && buf_ready)
        pend_v_q <= 1'b0;
      if (!oneport && dclk_rise)
      begin
        pend_i_q <= p1_s2;
        pend_q_q <= p2_s2;
        pend_v_q <= 1'b1;
      end
      else if (oneport && ilv_rise_q)
      begin
        if (!p2_s2[`P2_SEL_BIT])
        begin
          hold_i_q <= p1_s2;
          got_i_q <= 1'b1;
        end
        else if (got_i_q)
        begin
          pend_i_q <= hold_i_q;
          pend_q_q <= p1_s2;
          pend_v_q <= 1'b1;
          got_i_q <= 1'b0;
        end
      end
    end
  end

  pair_buffer #(
    .WIDTH(32),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data({pend_i_q, pend_q_q}),
    .in_valid(pend_v_q),
    .in_ready(buf_ready),
    .out_data(buf_out),
    .out_valid(pair_valid),
    .out_ready(pair_ready)
  );

  assign i_data = buf_out[31:16];
  assign q_data = buf_out[15:0];
endmodule

// ### verif/dac_clock_mode_and_port_select_properties.sv
// port-level checks for the clock-mode and port-select block
`timescale 1ns/100ps
module dac_clock_mode_and_port_select_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic shared_clkout_lock_pin,
  input wire logic serial_data_out_pin,
  input wire dac_clk_pkg::word_t i_data,
  input wire dac_clk_pkg::word_t q_data,
  input wire logic pair_valid,
  input wire logic pair_ready,
  input wire logic [3:0] rate_enable,
  input wire logic [7:0] vco_multiple,
  input wire logic [4:0] dac_rate_multiple
);
  import dac_clk_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence wr_answer;
    ##2 bvalid;
  endsequence
  chk_write_answered: assert property (wr_taken |-> wr_answer)
    else $error("write response missing");
  chk_read_answered: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  chk_pair_held: assert property (pair_valid && !pair_ready |=>
    pair_valid && $stable(i_data) && $stable(q_data))
    else $error("pending pair changed");
  chk_pin_exclusive: assert property (!(shared_clkout_lock_pin &&
    serial_data_out_pin))
    else $error("both clock pins high");
  chk_base_pulse: assert property (rate_enable[0] |=>
    !rate_enable[0] [*4])
    else $error("base enable too dense");
  chk_loop_off_rate: assert property (vco_multiple == 8'h00 |->
    dac_rate_multiple == 5'h01)
    else $error("sample-rate multiple wrong");
  chk_vco_product: assert property (vco_multiple != 8'h00 |->
    (vco_multiple % dac_rate_multiple) == 8'h00)
    else $error("oscillator multiple not a product");
  chk_rate_power: assert property ($onehot(dac_rate_multiple))
    else $error("rate multiple not a power of two");
endmodule
bind dac_clock_mode_and_port_select
  dac_clock_mode_and_port_select_properties chk_u (.*);

// ### verif/data_source_model.sv
// data source model: main clock and input port words
`timescale 1ns/100ps
module data_source_model (
  input wire logic oneport,
  input wire logic ilv_clk,
  output logic main_clock_in,
  output dac_clk_pkg::word_t port1_in,
  output logic [14:0] port2_lo
);
  import dac_clk_pkg::*;
  word_t tw = '0;
  word_t c = '0;
  initial
  begin
    main_clock_in = 1'b0;
    forever #62.5 main_clock_in = ~main_clock_in;
  end
  always @(negedge main_clock_in)
    tw <= tw + 16'h0001;
  always @(negedge ilv_clk)
    c <= c + 16'h0001;
  assign port1_in = oneport ? {c[0], c[15:1]} : tw;
  assign port2_lo = oneport ? {c[0], 14'h0} : ~tw[14:0];
endmodule

// ### verif/dac_clock_mode_and_port_select_tb.sv
// self-checking bench for the clock-mode and port-select block
`timescale 1ns/100ps
`include "dac_clk_map.svh"
module dac_clock_mode_and_port_select_tb;
  import dac_clk_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, main_clock_in, oneport;
  logic shared_clkout_lock_pin, serial_data_out_pin, ilv_out, ilv_oe;
  logic pair_valid, pair_ready, dac_output_enable;
  logic [7:0] awaddr, araddr, vco_multiple;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, rate_enable;
  logic [1:0] bresp, rresp, rsp;
  logic [4:0] dac_rate_multiple;
  logic [14:0] port2_lo;
  word_t port1_in, port2_in, i_data, q_data, i0, q0, i1, q1;
  int mismatches = 0;
  int samples_checked = 0;
  int k;
  int ni, nm;
  assign port2_in = {ilv_oe ? ilv_out : ~port2_lo[14], port2_lo};
  dac_clock_mode_and_port_select #(.LOCK_PERIODS(4)) dut_u (.*,
    .second_port_bit_fifteen_out(ilv_out),
    .second_port_bit_fifteen_oe(ilv_oe));
  data_source_model src_u (.oneport(oneport), .ilv_clk(port2_in[15]),
    .main_clock_in(main_clock_in), .port1_in(port1_in),
    .port2_lo(port2_lo));
  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
    repeat (2) @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    chk(rd, e);
  endtask
  task automatic pins(input logic es, input logic ed);
    logic s, d;
    s = 1'b0;
    d = 1'b0;
    repeat (40)
    begin
      @(posedge aclk);
      s = s | shared_clkout_lock_pin;
      d = d | serial_data_out_pin;
    end
    chk(32'({s, d}), 32'({es, ed}));
  endtask
  task automatic count_rises(output int ri, output int rm);
    logic pi, pm;
    ri = 0;
    rm = 0;
    pi = ilv_out;
    pm = main_clock_in;
    repeat (200)
    begin
      @(posedge aclk);
      if (ilv_out && !pi)
        ri++;
      if (main_clock_in && !pm)
        rm++;
      pi = ilv_out;
      pm = main_clock_in;
    end
  endtask
  task automatic take(output word_t i, output word_t q);
    @(posedge aclk);
    pair_ready <= 1'b1;
    do @(posedge aclk); while (pair_valid !== 1'b1);
    i = i_data;
    q = q_data;
    pair_ready <= 1'b0;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    #900000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, pair_ready, oneport} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 8; k++)
      rc(8'(4 * k), 32'h0);
    chk(32'(dac_rate_multiple), 32'h1);
    rc(8'h20, 32'h0);
    chk(32'(rsp), 32'(`RESP_SLVERR));
    wr(8'h40, 32'h1);
    chk(32'(rsp), 32'(`RESP_SLVERR));
    wr(8'h08, 32'h80);
    rc(8'h10, 32'h80);
    for (k = 0; k < 32; k++)
    begin
      wr(8'h14, 32'(k));
      chk(32'(vco_multiple), 32'(1) << (k % 4 + k / 4 % 4 + k / 16));
      chk(32'(dac_rate_multiple), 32'(1) << (k % 4 + k / 16));
    end
    rc(8'h1c, 32'h80);
    wr(8'h14, 32'h0);
    repeat (300) @(posedge aclk);
    rc(8'h00, 32'h2);
    pins(1'b1, 1'b0);
    wr(8'h0c, 32'h80);
    pins(1'b0, 1'b1);
    wr(8'h04, 32'h1);
    pins(1'b0, 1'b1);
    wr(8'h08, 32'h0);
    pins(1'b0, 1'b1);
    wr(8'h0c, 32'h0);
    pins(1'b1, 1'b0);
    wr(8'h00, 32'h10);
    chk(32'(dac_output_enable), 32'h0);
    pins(1'b1, 1'b0);
    wr(8'h00, 32'h0);
    chk(32'(dac_output_enable), 32'h1);
    wr(8'h00, 32'h08);
    pins(1'b0, 1'b0);
    rc(8'h00, 32'h08);
    chk(32'(dac_output_enable), 32'h0);
    wr(8'h00, 32'h0);
    repeat (64) @(posedge aclk);
    take(i0, q0);
    take(i1, q1);
    chk(32'(q0), 32'({i0[14], ~i0[14:0]}));
    chk(32'(i1), 32'(i0 + 16'h1));
    repeat (250) @(posedge aclk);
    rc(8'h18, 32'h1);
    take(i0, q0);
    take(i1, q1);
    chk(32'(i1), 32'(i0 + 16'h1));
    @(posedge aclk);
    pair_ready <= 1'b1;
    wr(8'h18, 32'h1);
    rc(8'h18, 32'h0);
    oneport <= 1'b1;
    wr(8'h14, 32'h21);
    wr(8'h08, 32'h80);
    repeat (100) @(posedge aclk);
    chk(32'(ilv_oe), 32'h1);
    count_rises(ni, nm);
    chk(32'((ni >= 2 * nm - 3) && (ni <= 2 * nm + 3)), 32'h1);
    for (k = 0; k < 5; k++)
      take(i0, q0);
    chk(32'(q0), 32'(i0 ^ 16'h8000));
    chk(32'(i0[15]), 32'h0);
    end_of_test();
  end
endmodule
